// [rtl/tmc_pkg.sv]
// Constants and types for the transceiver management register bank
package tmc_pkg;
    // Serial bus device address (A2h on the wire)
    localparam logic [6:0] TMC_DEV_ADDR = 7'h51;
    // Byte offsets
    localparam logic [7:0] TMC_OFS_EQ_HI = 8'h28;
    localparam logic [7:0] TMC_OFS_EQ_LO = 8'h29;
    localparam logic [7:0] TMC_OFS_EM_HI = 8'h2A;
    localparam logic [7:0] TMC_OFS_EM_LO = 8'h2B;
    localparam logic [7:0] TMC_OFS_FREE_LO = 8'h2C;
    localparam logic [7:0] TMC_OFS_FREE_HI = 8'h37;
    localparam logic [7:0] TMC_OFS_CHKSUM = 8'h5F;
    localparam logic [7:0] TMC_OFS_SOFT_CTL = 8'h6E;
    localparam logic [7:0] TMC_OFS_WRAP = 8'h6F;
    localparam logic [7:0] TMC_OFS_ALM_PRI = 8'h70;
    localparam logic [7:0] TMC_OFS_ALM_RX = 8'h71;
    localparam logic [7:0] TMC_OFS_WRN_PRI = 8'h74;
    localparam logic [7:0] TMC_OFS_WRN_RX = 8'h75;
    localparam logic [7:0] TMC_OFS_RATE_PWR = 8'h76;
    // Factory values and restore code
    localparam logic [7:0] TMC_RST_EQ_HI = 8'h02;
    localparam logic [7:0] TMC_RST_EQ_LO = 8'h04;
    localparam logic [7:0] TMC_RST_EM_HI = 8'h04;
    localparam logic [7:0] TMC_RST_EM_LO = 8'h02;
    localparam logic [7:0] TMC_RESTORE = 8'hFF;
    // Field positions
    localparam int TMC_BIT_SOFT_RATE = 3;
    localparam int TMC_EQ_W = 3;
    localparam int TMC_EM_W = 4;
    // Synchroniser lanes and their idle levels
    localparam int TMC_SY_SCL = 0;
    localparam int TMC_SY_SDA = 1;
    localparam int TMC_SY_TXR = 2;
    localparam int TMC_SY_RXR = 3;
    localparam logic [3:0] TMC_SY_RST = 4'h3;
    localparam logic [3:0] TMC_BYTE_BITS = 4'h8;
    // Checksum upkeep time
    localparam int TMC_CLK_PERIOD_NS = 5;
    localparam int TMC_CHK_UPDATE_MS = 100;
    localparam int TMC_CHK_UPDATE_CYC = TMC_CHK_UPDATE_MS * 1000000 / TMC_CLK_PERIOD_NS;
    // Wrap mode codes
    typedef enum logic [3:0] {
        TMC_WRAP_NONE = 4'b0000,
        TMC_WRAP_ELECTRICAL_LOOPBACK = 4'b0001,
        TMC_WRAP_ELECTRICAL_LOOPBACK_PASSTHROUGH = 4'b0011,
        TMC_WRAP_OPTICAL_LOOPBACK = 4'b0100,
        TMC_WRAP_OPTICAL_LOOPBACK_PASSTHROUGH = 4'b1100
    } tmc_wrap_e;
    // Serial slave states
    typedef enum logic [2:0] {
        TMC_ST_IDLE = 3'b000,
        TMC_ST_DEVADDR = 3'b001,
        TMC_ST_WORD = 3'b010,
        TMC_ST_WDATA = 3'b011,
        TMC_ST_ACK = 3'b100,
        TMC_ST_RDATA = 3'b101,
        TMC_ST_RDACK = 3'b110
    } tmc_state_e;
    // Data path steering
    typedef struct packed {
        logic opt_rx_to_tx_opt;
        logic opt_rx_to_rx_elec;
        logic elec_tx_to_rx_elec;
        logic elec_tx_to_tx_opt;
    } tmc_route_s;
    // Monitor flags, high flag above low flag
    typedef struct packed {
        logic [7:0] alarm_pri;
        logic [1:0] alarm_rx;
        logic [7:0] warn_pri;
        logic [1:0] warn_rx;
    } tmc_flags_s;
endpackage

// [rtl/tmc_regs.sv]
// Management register bank with two-wire serial slave
//
// Contract
// [R1] Wrap code 1100 sends received optical data to optical and electrical outputs.
// [R2] Wrap code 0100 sends received optical data to the optical output only.
// [R3] Wrap code 0011 sends transmit electrical data to electrical and optical outputs.
// [R4] Wrap code 0001 sends transmit electrical data back to the electrical output.
// [R5] Code 0000 cancels wraps; undefined codes are ignored, mode kept.
// [R6] First alarm byte holds eight high/low alarm flags, bit 7 down.
// [R7] Second alarm byte: receive power high bit 7, low bit 6, rest reserved.
// [R8] First warning byte mirrors alarm layout for the warning thresholds.
// [R9] Second warning byte: receive power high bit 7, low bit 6.
// [R10] Soft transmit rate bit 3 of byte 118 ORed with pin gives high rate.
// [R11] Power level state bit always reads zero.
// [R12] Power level select bit has no effect.
// [R13] Equalization uses byte 40 at high transmit rate, byte 41 at low.
// [R14] Only low three equalization bits are used; zero means no gain.
// [R15] Emphasis uses byte 42 at high receive rate, byte 43 at low.
// [R16] Only low four emphasis bits are used; zero means no emphasis.
// [R17] Writing FFh or reset restores factory equalization and emphasis values.
// [R18] Checksum byte 95 is recomputed within 100 ms of any change.
// [R19] Unallocated bytes 44 to 55 read as zero.
// [R20] Soft receive rate bit ORed with pin selects high rate and emphasis byte.
// [R21] Reserved bits read zero and ignore writes.
module tmc_regs #(
    parameter logic [7:0] CHK_BASE = 8'h00,
    parameter int CHK_UPDATE_CYC = tmc_pkg::TMC_CHK_UPDATE_CYC
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic tx_rate_select,
    input wire logic rx_rate_select,
    input wire tmc_pkg::tmc_flags_s flags,
    output tmc_pkg::tmc_route_s route,
    output logic tx_rate_high,
    output logic rx_rate_high,
    output logic [tmc_pkg::TMC_EQ_W-1:0] input_equalization,
    output logic [tmc_pkg::TMC_EM_W-1:0] rx_emphasis
);
    import tmc_pkg::*;

    logic [3:0] pins;
    logic [3:0] sy1_q, sy2_q, sy3_q, syv_q, syp_q;
    logic scl_rise, scl_fall, bus_start, bus_stop, sda_v, addr_hit, wr_en;
    tmc_state_e st_q, st_d, nxt_q, nxt_d;
    logic [7:0] sh_q, sh_d, ptr_q, ptr_d, rd_data;
    logic [3:0] cnt_q, cnt_d;
    logic mack_q, mack_d;
    logic [7:0] eq_hi_q, eq_lo_q, em_hi_q, em_lo_q, chk_q, chk_sum;
    logic [7:0] eq_hi_d, eq_lo_d, em_hi_d, em_lo_d;
    logic soft_tx_q, soft_rx_q, tx_hi_w, rx_hi_w;
    tmc_wrap_e wrap_q, wrap_d;
    logic wrap_valid;
    tmc_route_s route_q, route_d;
    tmc_flags_s flags_q;
    logic tx_hi_q, rx_hi_q;
    logic [TMC_EQ_W-1:0] eq_q;
    logic [TMC_EM_W-1:0] em_q;
    logic [31:0] pend_q;

    // Pin lanes gathered for the synchronisers
    assign pins = {rx_rate_select, tx_rate_select, sda_in, scl};

    // Three-stage synchronisers; value moves when stages two and three agree
    genvar g;
    for (g = 0; g < 4; g++) begin : g_sync
        always_ff @(posedge clock or negedge arst_n) begin
            if (!arst_n) begin
                sy1_q[g] <= TMC_SY_RST[g];
                sy2_q[g] <= TMC_SY_RST[g];
                sy3_q[g] <= TMC_SY_RST[g];
                syv_q[g] <= TMC_SY_RST[g];
                syp_q[g] <= TMC_SY_RST[g];
            end else begin
                sy1_q[g] <= pins[g];
                sy2_q[g] <= sy1_q[g];
                sy3_q[g] <= sy2_q[g];
                if (sy2_q[g] == sy3_q[g]) begin
                    syv_q[g] <= sy3_q[g];
                end
                syp_q[g] <= syv_q[g];
            end
        end
    end

    // Bus edge and condition detection
    assign sda_v = syv_q[TMC_SY_SDA];
    assign scl_rise = syv_q[TMC_SY_SCL] & ~syp_q[TMC_SY_SCL];
    assign scl_fall = ~syv_q[TMC_SY_SCL] & syp_q[TMC_SY_SCL];
    assign bus_start = syv_q[TMC_SY_SCL] & syp_q[TMC_SY_SCL] & syp_q[TMC_SY_SDA] & ~sda_v;
    assign bus_stop = syv_q[TMC_SY_SCL] & syp_q[TMC_SY_SCL] & ~syp_q[TMC_SY_SDA] & sda_v;
    assign addr_hit = sh_q[7:1] == TMC_DEV_ADDR;

    // Serial slave sequencing
    always_comb begin
        st_d = st_q;
        nxt_d = nxt_q;
        sh_d = sh_q;
        cnt_d = cnt_q;
        ptr_d = ptr_q;
        mack_d = mack_q;
        if (bus_start) begin
            st_d = TMC_ST_DEVADDR;
            cnt_d = 4'h0;
        end else if (bus_stop) begin
            st_d = TMC_ST_IDLE;
        end else begin
            case (st_q)
                TMC_ST_DEVADDR, TMC_ST_WORD, TMC_ST_WDATA: begin
                    if (scl_rise) begin
                        sh_d = {sh_q[6:0], sda_v};
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == TMC_BYTE_BITS) begin
                        cnt_d = 4'h0;
                        st_d = TMC_ST_ACK;
                        nxt_d = TMC_ST_WDATA;
                        if (st_q == TMC_ST_DEVADDR) begin
                            nxt_d = sh_q[0] ? TMC_ST_RDATA : TMC_ST_WORD;
                            if (!addr_hit) begin
                                st_d = TMC_ST_IDLE;
                            end
                        end else if (st_q == TMC_ST_WORD) begin
                            ptr_d = sh_q;
                        end else begin
                            ptr_d = ptr_q + 8'h01;
                        end
                    end
                end
                TMC_ST_ACK: begin
                    if (scl_fall) begin
                        st_d = nxt_q;
                        if (nxt_q == TMC_ST_RDATA) begin
                            sh_d = rd_data;
                            ptr_d = ptr_q + 8'h01;
                        end
                    end
                end
                TMC_ST_RDATA: begin
                    if (scl_rise) begin
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt_q == TMC_BYTE_BITS) begin
                            cnt_d = 4'h0;
                            st_d = TMC_ST_RDACK;
                        end else begin
                            sh_d = {sh_q[6:0], 1'b0};
                        end
                    end
                end
                TMC_ST_RDACK: begin
                    if (scl_rise) begin
                        mack_d = ~sda_v;
                    end else if (scl_fall) begin
                        if (mack_q) begin
                            st_d = TMC_ST_RDATA;
                            sh_d = rd_data;
                            ptr_d = ptr_q + 8'h01;
                        end else begin
                            st_d = TMC_ST_IDLE;
                        end
                    end
                end
                TMC_ST_IDLE: begin
                end
                default: begin
                    st_d = TMC_ST_IDLE;
                end
            endcase
        end
    end

    // Serial slave state registers
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= TMC_ST_IDLE;
            nxt_q <= TMC_ST_IDLE;
            sh_q <= 8'h00;
            cnt_q <= 4'h0;
            ptr_q <= 8'h00;
            mack_q <= 1'b0;
        end else begin
            st_q <= st_d;
            nxt_q <= nxt_d;
            sh_q <= sh_d;
            cnt_q <= cnt_d;
            ptr_q <= ptr_d;
            mack_q <= mack_d;
        end
    end

    // Open-drain data line: acknowledge or a zero data bit pulls low
    assign sda_out = 1'b0;
    assign sda_oe = (st_q == TMC_ST_ACK) | ((st_q == TMC_ST_RDATA) & ~sh_q[7]);
    assign wr_en = (st_q == TMC_ST_WDATA) & scl_fall & (cnt_q == TMC_BYTE_BITS)
                 & ~bus_start & ~bus_stop;

    // Tuning byte writes; FFh restores the factory value
    assign eq_hi_d = (sh_q == TMC_RESTORE) ? TMC_RST_EQ_HI : sh_q; // [R17]
    assign eq_lo_d = (sh_q == TMC_RESTORE) ? TMC_RST_EQ_LO : sh_q; // [R17]
    assign em_hi_d = (sh_q == TMC_RESTORE) ? TMC_RST_EM_HI : sh_q; // [R17]
    assign em_lo_d = (sh_q == TMC_RESTORE) ? TMC_RST_EM_LO : sh_q; // [R17]

    // Wrap code acceptance and steering decode
    assign wrap_valid = (sh_q[3:0] == TMC_WRAP_NONE)
                      | (sh_q[3:0] == TMC_WRAP_ELECTRICAL_LOOPBACK)
                      | (sh_q[3:0] == TMC_WRAP_ELECTRICAL_LOOPBACK_PASSTHROUGH)
                      | (sh_q[3:0] == TMC_WRAP_OPTICAL_LOOPBACK)
                      | (sh_q[3:0] == TMC_WRAP_OPTICAL_LOOPBACK_PASSTHROUGH); // [R5]
    assign wrap_d = (wr_en && ptr_q == TMC_OFS_WRAP && wrap_valid)
                  ? tmc_wrap_e'(sh_q[3:0]) : wrap_q; // [R5]
    assign route_d.opt_rx_to_tx_opt = (wrap_d == TMC_WRAP_OPTICAL_LOOPBACK_PASSTHROUGH)
                                    | (wrap_d == TMC_WRAP_OPTICAL_LOOPBACK); // [R1] [R2]
    assign route_d.opt_rx_to_rx_elec = (wrap_d == TMC_WRAP_OPTICAL_LOOPBACK_PASSTHROUGH)
                                     | (wrap_d == TMC_WRAP_NONE); // [R1] [R5]
    assign route_d.elec_tx_to_rx_elec = (wrap_d == TMC_WRAP_ELECTRICAL_LOOPBACK_PASSTHROUGH)
                                      | (wrap_d == TMC_WRAP_ELECTRICAL_LOOPBACK); // [R3] [R4]
    assign route_d.elec_tx_to_tx_opt = (wrap_d == TMC_WRAP_ELECTRICAL_LOOPBACK_PASSTHROUGH)
                                     | (wrap_d == TMC_WRAP_NONE); // [R3] [R5]

    // Rate selection: soft bit ORed with the pin
    assign tx_hi_w = soft_tx_q | syv_q[TMC_SY_TXR]; // [R10]
    assign rx_hi_w = soft_rx_q | syv_q[TMC_SY_RXR]; // [R20]
    assign chk_sum = CHK_BASE + eq_hi_q + eq_lo_q + em_hi_q + em_lo_q;

    // Control and status registers
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            eq_hi_q <= TMC_RST_EQ_HI; // [R17]
            eq_lo_q <= TMC_RST_EQ_LO;
            em_hi_q <= TMC_RST_EM_HI;
            em_lo_q <= TMC_RST_EM_LO;
            wrap_q <= TMC_WRAP_NONE;
            route_q <= 4'b0101;
            soft_tx_q <= 1'b0;
            soft_rx_q <= 1'b0;
            flags_q <= '0;
            chk_q <= 8'h00;
        end else begin
            if (wr_en && ptr_q == TMC_OFS_EQ_HI) eq_hi_q <= eq_hi_d;
            if (wr_en && ptr_q == TMC_OFS_EQ_LO) eq_lo_q <= eq_lo_d;
            if (wr_en && ptr_q == TMC_OFS_EM_HI) em_hi_q <= em_hi_d;
            if (wr_en && ptr_q == TMC_OFS_EM_LO) em_lo_q <= em_lo_d;
            if (wr_en && ptr_q == TMC_OFS_RATE_PWR) soft_tx_q <= sh_q[TMC_BIT_SOFT_RATE];
            if (wr_en && ptr_q == TMC_OFS_SOFT_CTL) soft_rx_q <= sh_q[TMC_BIT_SOFT_RATE];
            wrap_q <= wrap_d;
            route_q <= route_d;
            flags_q <= flags; // [R6] [R8]
            chk_q <= chk_sum; // [R18]
        end
    end

    // Rate and tuning outputs
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            tx_hi_q <= 1'b0;
            rx_hi_q <= 1'b0;
            eq_q <= '0;
            em_q <= '0;
        end else begin
            tx_hi_q <= tx_hi_w; // [R10]
            rx_hi_q <= rx_hi_w; // [R20]
            eq_q <= tx_hi_w ? eq_hi_q[TMC_EQ_W-1:0] : eq_lo_q[TMC_EQ_W-1:0]; // [R13] [R14]
            em_q <= rx_hi_w ? em_hi_q[TMC_EM_W-1:0] : em_lo_q[TMC_EM_W-1:0]; // [R15] [R16]
        end
    end

    assign route = route_q;
    assign tx_rate_high = tx_hi_q;
    assign rx_rate_high = rx_hi_q;
    assign input_equalization = eq_q;
    assign rx_emphasis = em_q;

    // Read selection; unmapped and unallocated bytes read zero
    assign rd_data = (ptr_q == TMC_OFS_EQ_HI) ? eq_hi_q :
                     (ptr_q == TMC_OFS_EQ_LO) ? eq_lo_q :
                     (ptr_q == TMC_OFS_EM_HI) ? em_hi_q :
                     (ptr_q == TMC_OFS_EM_LO) ? em_lo_q :
                     (ptr_q == TMC_OFS_CHKSUM) ? chk_q :
                     (ptr_q == TMC_OFS_SOFT_CTL) ?
                         {2'b00, syv_q[TMC_SY_TXR], syv_q[TMC_SY_RXR], soft_rx_q, 3'b000} :
                     (ptr_q == TMC_OFS_WRAP) ? {4'h0, wrap_q} : // [R21]
                     (ptr_q == TMC_OFS_ALM_PRI) ? flags_q.alarm_pri : // [R6]
                     (ptr_q == TMC_OFS_ALM_RX) ? {flags_q.alarm_rx, 6'h00} : // [R7]
                     (ptr_q == TMC_OFS_WRN_PRI) ? flags_q.warn_pri : // [R8]
                     (ptr_q == TMC_OFS_WRN_RX) ? {flags_q.warn_rx, 6'h00} : // [R9]
                     (ptr_q == TMC_OFS_RATE_PWR) ? {4'h0, soft_tx_q, 3'b000} : // [R11] [R12]
                     8'h00; // [R19]

    // Cycles the stored checksum has lagged the tuning bytes
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pend_q <= 32'h0000_0000;
        end else begin
            pend_q <= (chk_q != chk_sum) ? pend_q + 32'h0000_0001 : 32'h0000_0000;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    property p_wrap_opt_pass;
        wr_en && ptr_q == TMC_OFS_WRAP && sh_q[3:0] == 4'hC |=> route == 4'b1100;
    endproperty
    a_wrap_opt_pass: assert property (p_wrap_opt_pass) else $error("optical pass wrap"); // [R1]

    property p_wrap_opt;
        wr_en && ptr_q == TMC_OFS_WRAP && sh_q[3:0] == 4'h4 |=> route == 4'b1000;
    endproperty
    a_wrap_opt: assert property (p_wrap_opt) else $error("optical wrap"); // [R2]

    property p_wrap_elec_pass;
        wr_en && ptr_q == TMC_OFS_WRAP && sh_q[3:0] == 4'h3 |=> route == 4'b0011;
    endproperty
    a_wrap_elec_pass: assert property (p_wrap_elec_pass) else $error("elec pass wrap"); // [R3]

    property p_wrap_elec;
        wr_en && ptr_q == TMC_OFS_WRAP && sh_q[3:0] == 4'h1 |=> route == 4'b0010;
    endproperty
    a_wrap_elec: assert property (p_wrap_elec) else $error("electrical wrap"); // [R4]

    property p_wrap_keep;
        wr_en && ptr_q == TMC_OFS_WRAP && !wrap_valid |=> $stable(route) && $stable(wrap_q);
    endproperty
    a_wrap_keep: assert property (p_wrap_keep) else $error("invalid wrap code acted"); // [R5]

    property p_alm_rx;
        ptr_q == TMC_OFS_ALM_RX |-> rd_data == {flags_q.alarm_rx, 6'h00};
    endproperty
    a_alm_rx: assert property (p_alm_rx) else $error("receive alarm byte wrong"); // [R7]

    property p_tx_rate;
        soft_tx_q |=> tx_rate_high;
    endproperty
    a_tx_rate: assert property (p_tx_rate) else $error("soft rate not applied"); // [R10]

    property p_pwr_zero;
        ptr_q == TMC_OFS_RATE_PWR |-> rd_data[1:0] == 2'b00 && rd_data[3] == soft_tx_q;
    endproperty
    a_pwr_zero: assert property (p_pwr_zero) else $error("power bits not zero"); // [R11]

    property p_eq_sel;
        tx_hi_w |=> input_equalization == $past(eq_hi_q[TMC_EQ_W-1:0]);
    endproperty
    a_eq_sel: assert property (p_eq_sel) else $error("wrong equalization byte"); // [R13]

    property p_em_sel;
        !rx_hi_w |=> rx_emphasis == $past(em_lo_q[TMC_EM_W-1:0]);
    endproperty
    a_em_sel: assert property (p_em_sel) else $error("wrong emphasis byte"); // [R15]

    property p_restore;
        wr_en && ptr_q == TMC_OFS_EQ_HI && sh_q == TMC_RESTORE |=> eq_hi_q == TMC_RST_EQ_HI;
    endproperty
    a_restore: assert property (p_restore) else $error("factory restore failed"); // [R17]

    property p_chk_time;
        pend_q < CHK_UPDATE_CYC;
    endproperty
    a_chk_time: assert property (p_chk_time) else $error("checksum update late"); // [R18]

    property p_free_zero;
        ptr_q >= TMC_OFS_FREE_LO && ptr_q <= TMC_OFS_FREE_HI |-> rd_data == 8'h00;
    endproperty
    a_free_zero: assert property (p_free_zero) else $error("unallocated not zero"); // [R19]

    c_read: cover property (st_q == TMC_ST_RDACK && scl_fall && mack_q);
    c_tune_write: cover property (wr_en && ptr_q == TMC_OFS_EM_LO);
    c_wrap_change: cover property (wr_en && ptr_q == TMC_OFS_WRAP && wrap_valid);
    c_restore: cover property (wr_en && sh_q == TMC_RESTORE);
endmodule

// [sim/tb_top.sv]
// Self-checking bench for the management register bank
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [7:0] FAC [4] = '{8'h02, 8'h04, 8'h04, 8'h02};
    localparam logic [3:0] CODES [5] = '{4'hC, 4'h4, 4'h3, 4'h1, 4'h0};
    logic clock, arst_n, tx_rate_select, rx_rate_select, scl, host_low;
    logic sda_out, sda_oe, tx_rate_high, rx_rate_high;
    logic [2:0] input_equalization;
    logic [3:0] rx_emphasis;
    tmc_pkg::tmc_flags_s flags;
    tmc_pkg::tmc_route_s route;
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;
    // Open-drain data line with pull-up
    wire logic sda = !((sda_oe & !sda_out) | host_low);

    tmc_regs #(.CHK_UPDATE_CYC(16)) i_dut (.clock(clock), .arst_n(arst_n), .scl(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .tx_rate_select(tx_rate_select),
        .rx_rate_select(rx_rate_select), .flags(flags), .route(route),
        .tx_rate_high(tx_rate_high), .rx_rate_high(rx_rate_high),
        .input_equalization(input_equalization), .rx_emphasis(rx_emphasis));
    tmc_host i_host (.scl(scl), .sda_low(host_low), .sda(sda));

    // 200 MHz clock
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    // Hang guard
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            mismatches++;
            tally_and_finish();
        end
    end

    function automatic logic [3:0] route_of(input logic [3:0] c);
        case (c)
            4'hC: return 4'b1100;
            4'h4: return 4'b1000;
            4'h3: return 4'b0011;
            4'h1: return 4'b0010;
            default: return 4'b0101;
        endcase
    endfunction

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic reset_dut();
        @(negedge clock);
        arst_n = 1'b0;
        repeat (2) @(negedge clock);
        arst_n = 1'b1;
        repeat (10) @(negedge clock);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        logic k;
        i_host.write_reg(8'hA2, a, v, k);
        check("write ack", 8'h01, {7'h0, k});
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        logic k;
        i_host.read_reg(a, v, k);
        check("read ack", 8'h01, {7'h0, k});
        check($sformatf("byte %h", a), exp, v);
    endtask

    task automatic tally_and_finish();
        if (mismatches == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        logic [7:0] tun [4];
        logic [7:0] chk, ofs;
        logic [3:0] bad;
        logic ok;
        arst_n = 1'b0;
        tx_rate_select = 1'b0;
        rx_rate_select = 1'b0;
        flags = '0;
        chk = 8'($urandom(99819));
        reset_dut();
        check("route", 8'h05, {4'h0, route});
        check("equalization", 8'h04, {5'h0, input_equalization});
        check("emphasis", 8'h02, {4'h0, rx_emphasis});
        for (int k = 0; k < 4; k++) rdchk(8'h28 + 8'(k), FAC[k]);
        rdchk(8'h6F, 8'h00);
        rdchk(8'h5F, 8'h0C);
        // Each wrap code, followed by an undefined code that must be ignored
        foreach (CODES[i]) begin
            wr(8'h6F, {4'($urandom), CODES[i]});
            do bad = 4'($urandom); while (bad inside {4'hC, 4'h4, 4'h3, 4'h1, 4'h0});
            wr(8'h6F, {4'($urandom), bad});
            repeat (4) @(negedge clock);
            check("route", {4'h0, route_of(CODES[i])}, {4'h0, route});
            rdchk(8'h6F, {4'h0, CODES[i]});
        end
        // Monitor flags, all set first, then random
        for (int n = 0; n < 3; n++) begin
            @(negedge clock);
            flags = (n == 0) ? '1 : tmc_pkg::tmc_flags_s'($urandom);
            rdchk(8'h70, flags.alarm_pri);
            rdchk(8'h71, {flags.alarm_rx, 6'h00});
            rdchk(8'h74, flags.warn_pri);
            rdchk(8'h75, {flags.warn_rx, 6'h00});
        end
        // Tuning bytes with random settings
        for (int k = 0; k < 4; k++) begin
            do tun[k] = 8'($urandom); while (tun[k] == 8'hFF);
            wr(8'h28 + 8'(k), tun[k]);
            rdchk(8'h28 + 8'(k), tun[k]);
        end
        chk = tun[0] + tun[1] + tun[2] + tun[3];
        rdchk(8'h5F, chk);
        check("equalization", {5'h0, tun[1][2:0]}, {5'h0, input_equalization});
        check("emphasis", {4'h0, tun[2+1][3:0]}, {4'h0, rx_emphasis});
        // High rate by soft bits, then by pins
        for (int m = 0; m < 2; m++) begin
            wr(8'h76, (m == 0) ? 8'hFF : 8'h00);
            wr(8'h6E, (m == 0) ? 8'h08 : 8'h00);
            if (m == 0) rdchk(8'h76, 8'h08);
            @(negedge clock);
            tx_rate_select = 1'(m);
            rx_rate_select = 1'(m);
            repeat (12) @(negedge clock);
            check("tx rate", 8'h01, {7'h0, tx_rate_high});
            check("rx rate", 8'h01, {7'h0, rx_rate_high});
            check("equalization", {5'h0, tun[0][2:0]}, {5'h0, input_equalization});
            check("emphasis", {4'h0, tun[2][3:0]}, {4'h0, rx_emphasis});
        end
        tx_rate_select = 1'b0;
        rx_rate_select = 1'b0;
        // Unallocated bytes ignore writes
        repeat (3) begin
            ofs = 8'h2C + 8'($urandom_range(11));
            wr(ofs, 8'($urandom));
            rdchk(ofs, 8'h00);
        end
        // Factory restore code
        for (int k = 0; k < 4; k++) begin
            wr(8'h28 + 8'(k), 8'hFF);
            rdchk(8'h28 + 8'(k), FAC[k]);
        end
        rdchk(8'h5F, 8'h0C);
        // Foreign device address is not acknowledged and changes nothing
        i_host.write_reg(8'hA4, 8'h28, 8'h05, ok);
        check("stray ack", 8'h00, {7'h0, ok});
        rdchk(8'h28, 8'h02);
        // Power cycle reloads factory values
        wr(8'h29, 8'h07);
        reset_dut();
        check("equalization", 8'h04, {5'h0, input_equalization});
        rdchk(8'h29, 8'h04);
        tally_and_finish();
    end
endmodule

// [sim/tmc_host.sv]
// Two-wire host controller model driving the management bus
module tmc_host (
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 100ps;
    // Quarter of the 64 ns serial clock period
    localparam int Q = 16;

    // Bus idle: clock high, data released to its pull-up
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // Start or repeated start; waits first so a device ack can end
    task automatic start_cond();
        #Q;
        sda_low = 1'b0;
        #Q;
        scl = 1'b1;
        #Q;
        sda_low = 1'b1;
        #Q;
        scl = 1'b0;
    endtask

    // Stop: data rises while clock is high, then the clock stands still
    task automatic stop_cond();
        #Q;
        sda_low = 1'b1;
        #Q;
        scl = 1'b1;
        #Q;
        sda_low = 1'b0;
        #Q;
    endtask

    // One bit: data set mid low phase, sampled mid high phase
    task automatic bit_io(input logic b, output logic r);
        #Q;
        sda_low = !b;
        #Q;
        scl = 1'b1;
        #Q;
        r = sda;
        #Q;
        scl = 1'b0;
    endtask

    // Eight bits MSB first, then the ninth acknowledge bit
    task automatic byte_io(input logic [7:0] d, input logic last, output logic [7:0] q,
                           output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(last, ack);
    endtask

    // Single byte write; ok high when all three bytes were acknowledged
    task automatic write_reg(input logic [7:0] dev, input logic [7:0] ofs,
                             input logic [7:0] val, output logic ok);
        logic [7:0] q;
        logic a0, a1, a2;
        start_cond();
        byte_io(dev, 1'b1, q, a0);
        byte_io(ofs, 1'b1, q, a1);
        byte_io(val, 1'b1, q, a2);
        stop_cond();
        ok = !(a0 | a1 | a2);
    endtask

    // Pointer write, repeated start, one byte read closed by a no-ack
    task automatic read_reg(input logic [7:0] ofs, output logic [7:0] val, output logic ok);
        logic [7:0] q;
        logic a0, a1, a2, a3;
        start_cond();
        byte_io(8'hA2, 1'b1, q, a0);
        byte_io(ofs, 1'b1, q, a1);
        start_cond();
        byte_io(8'hA3, 1'b1, q, a2);
        byte_io(8'hFF, 1'b1, val, a3);
        stop_cond();
        ok = !(a0 | a1 | a2);
    endtask
endmodule
